// file: bench/sgp_pin_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// External board wiring of the three ports: every pin is resolved from the
// device driver and a weak external source that the bench commands.
module sgp_pin_model
  import sgp_pkg::*;
(
  input wire logic [PC_W-1:0] pc_out_in,
  input wire logic [PC_W-1:0] pc_oe_in,
  input wire logic [PC_W-1:0] pc_ext_in,
  input wire logic [PD_W-1:0] pd_out_in,
  input wire logic [PD_W-1:0] pd_oe_in,
  input wire logic [PD_W-1:0] pd_ext_in,
  input wire logic [PE_W-1:0] pe_out_in,
  input wire logic [PE_W-1:0] pe_oe_in,
  input wire logic [PE_W-1:0] pe_ext_in,
  output logic [PC_W-1:0] pc_pin_out,
  output logic [PD_W-1:0] pd_pin_out,
  output logic [PE_W-1:0] pe_pin_out
);
  // The device driver overpowers the external source, which is resistive.
  // A floating pin is never left unknown, since the source always drives.
  assign pc_pin_out = (pc_out_in & pc_oe_in) | (pc_ext_in & ~pc_oe_in);
  assign pd_pin_out = (pd_out_in & pd_oe_in) | (pd_ext_in & ~pd_oe_in);
  assign pe_pin_out = (pe_out_in & pe_oe_in) | (pe_ext_in & ~pe_oe_in);
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb;
  import sgp_pkg::*;
  logic sys_clk, rst;
  sgp_bus_req_t req;
  logic [7:0] rdata, failures, cmp_count;
  logic [PC_W-1:0] pc_in, pc_out, pc_oe, ext_c;
  logic [PD_W-1:0] pd_in, pd_out, pd_oe, ext_d, elsh, elsl, tdrv, tdrv_en, tpin;
  logic [PE_W-1:0] pe_in, pe_out, pe_oe, ext_e;
  logic sen, txd, rxd, a, b;
  // Clock of 4 ns period.
  always #2 sys_clk = ~sys_clk;
  sgp_ports sgp_ports_i (.sys_clk_in(sys_clk), .rst_in(rst), .bus_req_in(req),
    .rd_data_out(rdata), .pc_pin_in(pc_in), .pc_pin_out(pc_out), .pc_pin_oe_out(pc_oe),
    .pd_pin_in(pd_in), .pd_pin_out(pd_out), .pd_pin_oe_out(pd_oe), .pe_pin_in(pe_in),
    .pe_pin_out(pe_out), .pe_pin_oe_out(pe_oe), .edge_level_select_high_in(elsh),
    .edge_level_select_low_in(elsl), .timer_drive_in(tdrv), .timer_drive_en_in(tdrv_en),
    .timer_channel_pin_out(tpin), .serial_unit_enable_in(sen), .serial_txd_in(txd),
    .serial_rxd_out(rxd));
  sgp_pin_model sgp_pin_model_i (.pc_out_in(pc_out), .pc_oe_in(pc_oe), .pc_ext_in(ext_c),
    .pd_out_in(pd_out), .pd_oe_in(pd_oe), .pd_ext_in(ext_d), .pe_out_in(pe_out),
    .pe_oe_in(pe_oe), .pe_ext_in(ext_e), .pc_pin_out(pc_in), .pd_pin_out(pd_in),
    .pe_pin_out(pe_in));
  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the outcome.
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count = cmp_count + 8'h01;
    if (seen !== exp) begin
      failures = failures + 8'h01;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe, released at the edge that takes it.
  task wr(input logic [7:0] adr, input logic [7:0] dat);
    @(posedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: adr, wdata: dat};
    @(posedge sys_clk);
    req <= '0;
  endtask
  // One-cycle read strobe; the data stand only in the following cycle.
  task rdchk(input logic [7:0] adr, input logic [7:0] exp);
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: adr, wdata: 8'h00};
    @(posedge sys_clk);
    req <= '0;
    #1 chk(rdata, exp);
  endtask
  // Lets a register change pass through to the pins and back through the synchronisers.
  task settle();
    repeat (5) @(posedge sys_clk);
    #1;
  endtask
  task end_sim();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 8'h00 && cmp_count != 8'h00) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under 1000 cycles.
  initial begin
    #20000;
    failures = failures + 8'h01;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    req = '0;
    failures = 8'h00;
    cmp_count = 8'h00;
    ext_c = 5'h15;
    ext_d = 2'h2;
    ext_e = 2'h1;
    elsh = 2'h0;
    elsl = 2'h0;
    tdrv = 2'h0;
    tdrv_en = 2'h0;
    sen = 1'b0;
    txd = 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk(OFS_PORT_C_DIRECTION, 8'h00);
    rdchk(OFS_PORT_D_DIRECTION, 8'h00);
    rdchk(OFS_PORT_E_DIRECTION, 8'h00);
    chk({3'h0, pc_oe}, 8'h00);
    chk({4'h0, pd_oe, pe_oe}, 8'h00);
    rdchk(8'h55, 8'h00);
    // Port C: latch loaded ahead of the direction change.
    wr(OFS_PORT_C_PIN_DATA, 8'h0A);
    rdchk(OFS_PORT_C_PIN_DATA, 8'h15);
    wr(OFS_PORT_C_DIRECTION, 8'h03);
    settle();
    rdchk(OFS_PORT_C_PIN_DATA, 8'h16);
    chk({3'h0, pc_oe}, 8'h03);
    chk({3'h0, pc_out}, 8'h02);
    // Clock out on pin two: it toggles, reads zero and ignores writes.
    wr(OFS_PORT_C_DIRECTION, 8'h87);
    settle();
    a = pc_out[PC_CLK_BIT];
    @(posedge sys_clk);
    #1 b = pc_out[PC_CLK_BIT];
    chk({6'h0, pc_oe[PC_CLK_BIT], a ^ b}, 8'h03);
    rdchk(OFS_PORT_C_PIN_DATA, 8'h12);
    wr(OFS_PORT_C_PIN_DATA, 8'h0E);
    rdchk(OFS_PORT_C_PIN_DATA, 8'h12);
    wr(OFS_PORT_C_DIRECTION, 8'h07);
    settle();
    chk({3'h0, pc_out}, 8'h06);
    // Port D as plain I/O, then handed to the timer.
    rdchk(OFS_PORT_D_PIN_DATA, 8'h02);
    wr(OFS_PORT_D_PIN_DATA, 8'h01);
    wr(OFS_PORT_D_DIRECTION, 8'h01);
    settle();
    chk({4'h0, pd_oe, pd_out}, 8'h05);
    rdchk(OFS_PORT_D_PIN_DATA, 8'h03);
    chk({6'h0, tpin}, 8'h03);
    // The timer drives a one where the latch holds a zero, so the two differ.
    @(posedge sys_clk);
    elsh <= 2'h2;
    tdrv_en <= 2'h2;
    tdrv <= 2'h2;
    settle();
    chk({4'h0, pd_oe, pd_out}, 8'h0F);
    rdchk(OFS_PORT_D_PIN_DATA, 8'h03);
    wr(OFS_PORT_D_DIRECTION, 8'h03);
    @(posedge sys_clk);
    elsh <= 2'h0;
    elsl <= 2'h2;
    tdrv_en <= 2'h0;
    settle();
    chk({6'h0, pd_oe}, 8'h01);
    rdchk(OFS_PORT_D_PIN_DATA, 8'h01);
    @(posedge sys_clk);
    elsl <= 2'h0;
    settle();
    chk({6'h0, pd_oe}, 8'h03);
    // Port E as plain I/O, then handed to the serial unit.
    wr(OFS_PORT_E_PIN_DATA, 8'h03);
    rdchk(OFS_PORT_E_PIN_DATA, 8'h01);
    @(posedge sys_clk);
    sen <= 1'b1;
    txd <= 1'b0;
    ext_e <= 2'h1;
    wr(OFS_PORT_E_DIRECTION, 8'h02);
    settle();
    chk({4'h0, pe_oe, pe_out}, 8'h04);
    chk({7'h0, rxd}, 8'h00);
    rdchk(OFS_PORT_E_PIN_DATA, 8'h02);
    @(posedge sys_clk);
    ext_e <= 2'h2;
    txd <= 1'b1;
    settle();
    chk({6'h0, rxd, pe_out[PE_TX_BIT]}, 8'h03);
    @(posedge sys_clk);
    sen <= 1'b0;
    settle();
    chk({4'h0, pe_oe, pe_out}, 8'h0A);
    chk({7'h0, rxd}, 8'h01);
    // A second reset keeps the port E latch but clears its direction.
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk(OFS_PORT_E_DIRECTION, 8'h00);
    wr(OFS_PORT_E_DIRECTION, 8'h03);
    rdchk(OFS_PORT_E_PIN_DATA, 8'h03);
    end_sim();
  end
endmodule

// file: design/sgp_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Shared constants and carriers for the three small general-purpose ports.
////////////////////////////////////////////////////////////////////////////////
package sgp_pkg;

  // Width of the register address and of the register data.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Number of pins on each port.
  localparam int PC_W = 5;
  localparam int PD_W = 2;
  localparam int PE_W = 2;

  // Byte offsets of the data registers.
  localparam logic [ADDR_W-1:0] OFS_PORT_C_PIN_DATA = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_PORT_D_PIN_DATA = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_PORT_E_PIN_DATA = 8'h08;

  // Byte offsets of the direction registers.
  localparam logic [ADDR_W-1:0] OFS_PORT_C_DIRECTION = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_PORT_D_DIRECTION = 8'h07;
  localparam logic [ADDR_W-1:0] OFS_PORT_E_DIRECTION = 8'h0C;

  // Field positions.
  localparam int PC_CLK_BIT = 2;
  localparam int PC_CLKEN_BIT = 7;
  localparam int PE_RX_BIT = 1;
  localparam int PE_TX_BIT = 0;

  // Values after reset.
  localparam logic [PC_W-1:0] PC_DIR_RST = 5'h00;
  localparam logic PC_CLKEN_RST = 1'b0;
  localparam logic [PD_W-1:0] PD_DIR_RST = 2'h0;
  localparam logic [PE_W-1:0] PE_DIR_RST = 2'h0;
  localparam logic [DATA_W-1:0] RD_DATA_RST = 8'h00;
  localparam logic RXD_IDLE = 1'b1;

  // One register access from software.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sgp_bus_req_t;

  // Every flip-flop of the port block.
  typedef struct packed {
    logic [PC_W-1:0] port_c_latch;
    logic [PD_W-1:0] port_d_latch;
    logic [PE_W-1:0] port_e_latch;
    logic [PC_W-1:0] port_c_direction;
    logic clock_output_enable;
    logic [PD_W-1:0] port_d_direction;
    logic [PE_W-1:0] port_e_direction;
    logic [PC_W-1:0] pc_sync1;
    logic [PC_W-1:0] pc_sync2;
    logic [PD_W-1:0] pd_sync1;
    logic [PD_W-1:0] pd_sync2;
    logic [PE_W-1:0] pe_sync1;
    logic [PE_W-1:0] pe_sync2;
    logic [DATA_W-1:0] rd_data;
    logic [PC_W-1:0] pc_out;
    logic [PC_W-1:0] pc_oe;
    logic [PD_W-1:0] pd_out;
    logic [PD_W-1:0] pd_oe;
    logic [PE_W-1:0] pe_out;
    logic [PE_W-1:0] pe_oe;
    logic clk_toggle;
    logic [PD_W-1:0] timer_pin;
    logic rxd;
  } sgp_state_t;

endpackage

// file: design/sgp_ports.sv
`timescale 1ns/1ps
module sgp_ports
  import sgp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire sgp_bus_req_t bus_req_in,
  output logic [DATA_W-1:0] rd_data_out,
  input wire logic [PC_W-1:0] pc_pin_in,
  output logic [PC_W-1:0] pc_pin_out,
  output logic [PC_W-1:0] pc_pin_oe_out,
  input wire logic [PD_W-1:0] pd_pin_in,
  output logic [PD_W-1:0] pd_pin_out,
  output logic [PD_W-1:0] pd_pin_oe_out,
  input wire logic [PE_W-1:0] pe_pin_in,
  output logic [PE_W-1:0] pe_pin_out,
  output logic [PE_W-1:0] pe_pin_oe_out,
  input wire logic [PD_W-1:0] edge_level_select_high_in,
  input wire logic [PD_W-1:0] edge_level_select_low_in,
  input wire logic [PD_W-1:0] timer_drive_in,
  input wire logic [PD_W-1:0] timer_drive_en_in,
  output logic [PD_W-1:0] timer_channel_pin_out,
  input wire logic serial_unit_enable_in,
  input wire logic serial_txd_in,
  output logic serial_rxd_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State and the combinational helpers that read it.
  ////////////////////////////////////////////////////////////////////////////

  // Registered state and its next value.
  sgp_state_t st_ff;
  sgp_state_t nxt_st;

  // Read value of each data register before the bus mux.
  logic [PC_W-1:0] pc_rd_mix;
  logic [PD_W-1:0] pd_rd_mix;
  logic [PE_W-1:0] pe_rd_mix;

  // Pin drive value and enable of port C, built per bit below.
  logic [PC_W-1:0] pc_drv_val;
  logic [PC_W-1:0] pc_drv_en;

  // Timer ownership of each port D pin.
  logic [PD_W-1:0] pd_timer_owned;

  // Serial ownership of the port E pins, as a per-bit mask.
  logic [PE_W-1:0] pe_serial_owned;

  // Timer takes pin.
  // A channel owns its pin as soon as either select bit is set.
  assign pd_timer_owned = edge_level_select_high_in | edge_level_select_low_in;

  // Serial takes pins.
  // Both port E pins move to the serial unit together with its enable.
  assign pe_serial_owned = {PE_W{serial_unit_enable_in}};

  // Port C read source.
  // Direction one shows the latch, zero the synchronised pin.
  // Clock bit reads zero.
  // While the clock is on pin two its bit is forced low on reads.
  assign pc_rd_mix = ((st_ff.port_c_direction & st_ff.port_c_latch)
                     | (~st_ff.port_c_direction & st_ff.pc_sync2))
                     & ~({{(PC_W-1){1'b0}}, st_ff.clock_output_enable} << PC_CLK_BIT);

  // Direction picks source.
  // Ownership by the timer plays no part in the read path.
  assign pd_rd_mix = (st_ff.port_d_direction & st_ff.port_d_latch)
                     | (~st_ff.port_d_direction & st_ff.pd_sync2);

  assign pe_rd_mix = (st_ff.port_e_direction & st_ff.port_e_latch)
                     | (~st_ff.port_e_direction & st_ff.pe_sync2);

  // Per-bit drive of port C; pin two alone can carry the clock.
  genvar gi;
  generate
    for (gi = 0; gi < PC_W; gi++) begin : g_pc_drive
      if (gi == PC_CLK_BIT) begin : g_clk
        // Clock on pin.
        // The clock enable overrides both the direction and the latch.
        assign pc_drv_en[gi] = st_ff.clock_output_enable | st_ff.port_c_direction[gi];
        assign pc_drv_val[gi] = st_ff.clock_output_enable ? st_ff.clk_toggle
                                                          : st_ff.port_c_latch[gi];
      end else begin : g_gpio
        assign pc_drv_en[gi] = st_ff.port_c_direction[gi];
        assign pc_drv_val[gi] = st_ff.port_c_latch[gi];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  ////////////////////////////////////////////////////////////////////////////

  // All next values are formed here; the clocked process only registers them.
  always_comb begin
    nxt_st = st_ff;
    // Two-stage pin synchronisers; only the second stage feeds logic.
    nxt_st.pc_sync1 = pc_pin_in;
    nxt_st.pc_sync2 = st_ff.pc_sync1;
    nxt_st.pd_sync1 = pd_pin_in;
    nxt_st.pd_sync2 = st_ff.pd_sync1;
    nxt_st.pe_sync1 = pe_pin_in;
    nxt_st.pe_sync2 = st_ff.pe_sync1;

    // Input write latch-only.
    // Writes land in the latch whatever the direction; the read path of an
    // input bit looks at the pin, so a write there never shows on a read.
    if (bus_req_in.wr) begin
      case (bus_req_in.addr)
        OFS_PORT_C_PIN_DATA: begin
          // The latch of pin two still stores while the clock is out, but
          // the drive mux ignores it until the clock is turned off.
          nxt_st.port_c_latch = bus_req_in.wdata[PC_W-1:0];
        end
        OFS_PORT_D_PIN_DATA: begin
          nxt_st.port_d_latch = bus_req_in.wdata[PD_W-1:0];
        end
        OFS_PORT_E_PIN_DATA: begin
          nxt_st.port_e_latch = bus_req_in.wdata[PE_W-1:0];
        end
        OFS_PORT_C_DIRECTION: begin
          nxt_st.port_c_direction = bus_req_in.wdata[PC_W-1:0];
          nxt_st.clock_output_enable = bus_req_in.wdata[PC_CLKEN_BIT];
        end
        OFS_PORT_D_DIRECTION: begin
          nxt_st.port_d_direction = bus_req_in.wdata[PD_W-1:0];
        end
        OFS_PORT_E_DIRECTION: begin
          nxt_st.port_e_direction = bus_req_in.wdata[PE_W-1:0];
        end
        default: begin
          // Writes to unmapped offsets are dropped.
        end
      endcase
    end

    // Read data stand only in the cycle after the strobe, else zero.
    nxt_st.rd_data = RD_DATA_RST;
    if (bus_req_in.rd) begin
      case (bus_req_in.addr)
        OFS_PORT_C_PIN_DATA: begin
          nxt_st.rd_data = {{(DATA_W-PC_W){1'b0}}, pc_rd_mix};
        end
        OFS_PORT_D_PIN_DATA: begin
          nxt_st.rd_data = {{(DATA_W-PD_W){1'b0}}, pd_rd_mix};
        end
        OFS_PORT_E_PIN_DATA: begin
          nxt_st.rd_data = {{(DATA_W-PE_W){1'b0}}, pe_rd_mix};
        end
        OFS_PORT_C_DIRECTION: begin
          // Bits six and five are unused and read as zero.
          nxt_st.rd_data = {st_ff.clock_output_enable, 2'h0, st_ff.port_c_direction};
        end
        OFS_PORT_D_DIRECTION: begin
          nxt_st.rd_data = {{(DATA_W-PD_W){1'b0}}, st_ff.port_d_direction};
        end
        OFS_PORT_E_DIRECTION: begin
          nxt_st.rd_data = {{(DATA_W-PE_W){1'b0}}, st_ff.port_e_direction};
        end
        default: begin
          // Unmapped offsets answer with zero.
          nxt_st.rd_data = RD_DATA_RST;
        end
      endcase
    end

    // The clock output is a half-rate square wave from a flop, because the
    // pin must come from a register and cannot carry the clock net itself.
    nxt_st.clk_toggle = st_ff.clock_output_enable ? ~st_ff.clk_toggle : 1'b0;

    // Latch drives pin.
    // The pin takes the latch on the edge after the direction turns to one, which
    // is why software is expected to load the latch first.
    nxt_st.pc_oe = pc_drv_en;
    nxt_st.pc_out = pc_drv_val & pc_drv_en;

    nxt_st.pd_oe = (pd_timer_owned & timer_drive_en_in)
                   | (~pd_timer_owned & st_ff.port_d_direction);
    nxt_st.pd_out = ((pd_timer_owned & timer_drive_in)
                    | (~pd_timer_owned & st_ff.port_d_latch)) & nxt_st.pd_oe;
    nxt_st.timer_pin = st_ff.pd_sync2;

    // Transmit on pin zero.
    // Owned receive pin floats, owned transmit pin always drives.
    nxt_st.pe_oe = (~pe_serial_owned & st_ff.port_e_direction)
                   | (pe_serial_owned & (PE_W'(1) << PE_TX_BIT));
    nxt_st.pe_out = ((~pe_serial_owned & st_ff.port_e_latch)
                    | (pe_serial_owned & ({PE_W{serial_txd_in}} & (PE_W'(1) << PE_TX_BIT))))
                    & nxt_st.pe_oe;
    // Receive from pin one.
    // A disabled serial unit sees an idle line.
    nxt_st.rxd = serial_unit_enable_in ? st_ff.pe_sync2[PE_RX_BIT] : RXD_IDLE;

    if (rst_in) begin
      nxt_st = '0;
      nxt_st.port_c_latch = st_ff.port_c_latch;
      nxt_st.port_d_latch = st_ff.port_d_latch;
      nxt_st.port_e_latch = st_ff.port_e_latch;
      nxt_st.port_c_direction = PC_DIR_RST;
      nxt_st.clock_output_enable = PC_CLKEN_RST;
      nxt_st.port_d_direction = PD_DIR_RST;
      nxt_st.port_e_direction = PE_DIR_RST;
      nxt_st.rd_data = RD_DATA_RST;
      nxt_st.rxd = RXD_IDLE;
    end
  end

  // Single register stage for the whole state; reset is folded in above.
  always_ff @(posedge sys_clk_in) begin
    st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flop.
  ////////////////////////////////////////////////////////////////////////////

  assign rd_data_out = st_ff.rd_data;
  assign pc_pin_out = st_ff.pc_out;
  assign pc_pin_oe_out = st_ff.pc_oe;
  assign pd_pin_out = st_ff.pd_out;
  assign pd_pin_oe_out = st_ff.pd_oe;
  assign pe_pin_out = st_ff.pe_out;
  assign pe_pin_oe_out = st_ff.pe_oe;
  assign timer_channel_pin_out = st_ff.timer_pin;
  assign serial_rxd_out = st_ff.rxd;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.
  ////////////////////////////////////////////////////////////////////////////

  // An all-input port C read returns the pins as they were three edges back.
  // Reads just after reset are left out, since reset empties the synchronisers.
  property p_pc_read_pin;
    @(posedge sys_clk_in) disable iff (rst_in)
      (bus_req_in.rd && bus_req_in.addr == OFS_PORT_C_PIN_DATA
       && st_ff.port_c_direction == 5'h00 && !st_ff.clock_output_enable
       && !$past(rst_in) && !$past(rst_in, 2))
      |=> rd_data_out == {3'h0, $past(pc_pin_in, 3)};
  endproperty
  a_pc_read_pin: assert property (p_pc_read_pin)
    else $error("port C input read does not show the pins");

  // An all-output port D read returns the latch, owned or not.
  property p_pd_read_latch;
    @(posedge sys_clk_in) disable iff (rst_in)
      (bus_req_in.rd && bus_req_in.addr == OFS_PORT_D_PIN_DATA
       && st_ff.port_d_direction == 2'h3)
      |=> rd_data_out == {6'h00, $past(st_ff.port_d_latch)};
  endproperty
  a_pd_read_latch: assert property (p_pd_read_latch)
    else $error("port D output read does not show the latch");

  // An all-input port E read shows the pins, never a just-written latch.
  property p_pe_read_pin;
    @(posedge sys_clk_in) disable iff (rst_in)
      (bus_req_in.rd && bus_req_in.addr == OFS_PORT_E_PIN_DATA
       && st_ff.port_e_direction == 2'h0
       && !$past(rst_in) && !$past(rst_in, 2))
      |=> rd_data_out == {6'h00, $past(pe_pin_in, 3)};
  endproperty
  a_pe_read_pin: assert property (p_pe_read_pin)
    else $error("port E input read does not show the pins");

  // A data write reaches the latch even with the pins set as inputs.
  property p_pc_write_latch;
    @(posedge sys_clk_in) disable iff (rst_in)
      (bus_req_in.wr && bus_req_in.addr == OFS_PORT_C_PIN_DATA)
      |=> st_ff.port_c_latch == $past(bus_req_in.wdata[4:0]);
  endproperty
  a_pc_write_latch: assert property (p_pc_write_latch)
    else $error("port C latch missed a write");

  // Every timer-owned pin follows the timer enable, not the direction bit.
  property p_pd_timer_oe;
    @(posedge sys_clk_in) disable iff (rst_in)
      (|pd_timer_owned)
      |=> (pd_pin_oe_out & $past(pd_timer_owned))
          == ($past(timer_drive_en_in) & $past(pd_timer_owned));
  endproperty
  a_pd_timer_oe: assert property (p_pd_timer_oe)
    else $error("timer-owned port D pin ignores the timer enable");

  // Port D pin one, when free, drives exactly when its direction bit is one.
  property p_pd_dir_oe;
    @(posedge sys_clk_in) disable iff (rst_in)
      !pd_timer_owned[1] |=> pd_pin_oe_out[1] == $past(st_ff.port_d_direction[1]);
  endproperty
  a_pd_dir_oe: assert property (p_pd_dir_oe)
    else $error("free port D pin driver does not follow direction");

  // Reset clears all direction bits and the clock enable by the next edge.
  property p_reset_dirs;
    @(posedge sys_clk_in)
      rst_in |=> (st_ff.port_c_direction == 5'h00 && !st_ff.clock_output_enable
                  && st_ff.port_d_direction == 2'h0 && st_ff.port_e_direction == 2'h0);
  endproperty
  a_reset_dirs: assert property (p_reset_dirs)
    else $error("direction bits not cleared by reset");

  // Reset does not disturb the port E latch; the case compare lets a latch
  // that was never written stay equal to itself through power-up reset.
  property p_reset_keeps_pe;
    @(posedge sys_clk_in)
      rst_in |=> st_ff.port_e_latch === $past(st_ff.port_e_latch);
  endproperty
  a_reset_keeps_pe: assert property (p_reset_keeps_pe)
    else $error("reset changed the port E latch");

  // With the serial unit on, pin zero drives transmit and pin one floats.
  property p_serial_pins;
    @(posedge sys_clk_in) disable iff (rst_in)
      serial_unit_enable_in |=> (pe_pin_oe_out == 2'h1
                                 && pe_pin_out[0] == $past(serial_txd_in));
  endproperty
  a_serial_pins: assert property (p_serial_pins)
    else $error("serial unit pins not handed over");

  // Three cycles of clock enable give a driven, toggling pin two.
  property p_clock_out;
    @(posedge sys_clk_in) disable iff (rst_in)
      st_ff.clock_output_enable [*3]
      |-> (pc_pin_oe_out[2] && pc_pin_out[2] != $past(pc_pin_out[2]));
  endproperty
  a_clock_out: assert property (p_clock_out)
    else $error("clock output on pin two not toggling");

  // Pin two reads zero while it carries the clock.
  property p_clock_bit_reads_zero;
    @(posedge sys_clk_in) disable iff (rst_in)
      (bus_req_in.rd && bus_req_in.addr == OFS_PORT_C_PIN_DATA
       && st_ff.clock_output_enable) |=> !rd_data_out[2];
  endproperty
  a_clock_bit_reads_zero: assert property (p_clock_bit_reads_zero)
    else $error("clock pin bit did not read zero");

  // Main scenarios worth seeing at least once.
  c_timer_owned: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    pd_timer_owned[1] ##1 pd_pin_oe_out[1]);
  c_serial_on: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    serial_unit_enable_in ##1 pe_pin_oe_out[0]);
  c_clock_out: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    st_ff.clock_output_enable [*3]);
  c_pc_output_read: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    bus_req_in.rd && bus_req_in.addr == OFS_PORT_C_PIN_DATA
    && st_ff.port_c_direction == 5'h1F);

endmodule
